// *** verilog/akg_key_gen.sv ***
// akg_key_gen: builds raw keys, range hits, vid and ingress mask fields per frame.
// assumes frames arrive one per valid cycle from the parser; results one cycle later.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module akg_key_gen
    import akg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata_q,
    input wire logic frame_valid,
    input wire akg_frame_t frame_in,
    output logic keys_valid_q,
    output akg_keys_t keys_q
);

    // private range, offset, mask and router leg configuration plus last hits, not shared with any other stage
    akg_rng_type_t rng_type_q [AKG_NUM_RNG];
    logic [15:0] rng_start_q [AKG_NUM_RNG];
    logic [15:0] rng_end_q [AKG_NUM_RNG];
    logic [7:0] field_offset_q;
    logic [3:0] misc_q;
    logic [AKG_NUM_PORTS-1:0] leg_ena_q;
    logic [AKG_NUM_RNG-1:0] last_hits_q;

    function automatic logic [7:0] frame_byte(input akg_frame_t f, input logic [7:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (idx < 8'(AKG_FRAME_BYTES)) begin
            b = f.bytes[idx*8 +: 8];
        end
        return b;
    endfunction

    // inclusive bounds
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic [AKG_NUM_PORTS-1:0] port_bit(input logic [AKG_PORT_W-1:0] p);
        logic [AKG_NUM_PORTS-1:0] m;
        m = '0;
        if (p < AKG_PORT_W'(AKG_NUM_PORTS)) begin
            m[p] = 1'b1;
        end
        return m;
    endfunction

    // register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < AKG_NUM_RNG; i++) begin
                rng_type_q[i] <= AKG_RNG_DPORT;
                rng_start_q[i] <= AKG_RST_ZERO[15:0];
                rng_end_q[i] <= AKG_RST_ZERO[15:0];
            end
            field_offset_q <= AKG_RST_ZERO[7:0];
            misc_q <= AKG_RST_ZERO[3:0];
            leg_ena_q <= {AKG_RST_ZERO[AKG_NUM_PORTS-33:0], AKG_RST_ZERO};
        end else if (clk_en && reg_write) begin
            for (int i = 0; i < AKG_NUM_RNG; i++) begin
                if (reg_addr == AKG_REG_TYPE_BASE + 8'(i)) begin
                    case (reg_wdata[2:0])
                        3'h0: rng_type_q[i] <= AKG_RNG_DPORT;
                        3'h1: rng_type_q[i] <= AKG_RNG_SPORT;
                        3'h2: rng_type_q[i] <= AKG_RNG_SDPORT;
                        3'h3: rng_type_q[i] <= AKG_RNG_VID;
                        3'h4: rng_type_q[i] <= AKG_RNG_DSCP;
                        3'h5: rng_type_q[i] <= AKG_RNG_FIELD;
                        default: rng_type_q[i] <= rng_type_q[i];
                    endcase
                end
                if (reg_addr == AKG_REG_BOUNDS_BASE + 8'(i)) begin
                    rng_start_q[i] <= reg_wdata[15:0];
                    rng_end_q[i] <= reg_wdata[31:16];
                end
            end
            if (reg_addr == AKG_REG_OFFSET) begin
                field_offset_q <= reg_wdata[7:0];
            end
            if (reg_addr == AKG_REG_MISC) begin
                misc_q <= reg_wdata[3:0];
            end
            if (reg_addr == AKG_REG_LEG_ENA_LO) begin
                leg_ena_q[31:0] <= reg_wdata;
            end
            if (reg_addr == AKG_REG_LEG_ENA_HI) begin
                leg_ena_q[AKG_NUM_PORTS-1:32] <= reg_wdata[AKG_NUM_PORTS-33:0];
            end
        end
    end

    // register reads, data valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata_q <= AKG_RST_ZERO;
        end else if (clk_en) begin
            reg_rdata_q <= AKG_RST_ZERO;
            if (reg_read) begin
                for (int i = 0; i < AKG_NUM_RNG; i++) begin
                    if (reg_addr == AKG_REG_TYPE_BASE + 8'(i)) begin
                        reg_rdata_q <= {29'h0, rng_type_q[i]};
                    end
                    if (reg_addr == AKG_REG_BOUNDS_BASE + 8'(i)) begin
                        reg_rdata_q <= {rng_end_q[i], rng_start_q[i]};
                    end
                end
                case (reg_addr)
                    AKG_REG_OFFSET: reg_rdata_q <= {24'h0, field_offset_q};
                    AKG_REG_MISC: reg_rdata_q <= {28'h0, misc_q};
                    AKG_REG_LEG_ENA_LO: reg_rdata_q <= leg_ena_q[31:0];
                    AKG_REG_LEG_ENA_HI: reg_rdata_q <= {11'h0, leg_ena_q[AKG_NUM_PORTS-1:32]};
                    AKG_REG_HITS: reg_rdata_q <= {24'h0, last_hits_q};
                    default: begin
                    end
                endcase
            end
        end
    end

    // raw key start position
    logic [7:0] raw_start;
    logic raw_pos_ok;
    always_comb begin
        raw_pos_ok = 1'b1;
        case (frame_in.raw_key_position)
            AKG_POS_LINK: begin
                raw_start = 8'h00;
                raw_pos_ok = !frame_in.control_word_frame;
            end
            AKG_POS_PAYLOAD: raw_start = frame_in.payload_pos;
            AKG_POS_PLUS20: raw_start = frame_in.payload_pos + AKG_PLUS20;
            AKG_POS_PLUS40: raw_start = frame_in.payload_pos + AKG_PLUS40;
            default: raw_start = 8'h00;
        endcase
    end

    // selected 16-bit field from type/len after up to three tags
    logic [15:0] sel_field;
    logic [7:0] sel_idx;
    always_comb begin
        sel_idx = frame_in.typelen_pos + field_offset_q;
        sel_field = {frame_byte(frame_in, sel_idx), frame_byte(frame_in, sel_idx + 8'h01)};
    end

    // range checkers
    logic [AKG_NUM_RNG-1:0] hits;
    logic rng_key;
    always_comb begin
        rng_key = (frame_in.key_type == AKG_KEY_IPV4_L4)
               || (frame_in.key_type == AKG_KEY_SEVEN_TUPLE);
        for (int i = 0; i < AKG_NUM_RNG; i++) begin
            case (rng_type_q[i])
                AKG_RNG_DPORT: hits[i] = frame_in.is_tcp_udp
                    && in_range(frame_in.dst_port, rng_start_q[i], rng_end_q[i]);
                AKG_RNG_SPORT: hits[i] = frame_in.is_tcp_udp
                    && in_range(frame_in.src_port, rng_start_q[i], rng_end_q[i]);
                AKG_RNG_SDPORT: hits[i] = frame_in.is_tcp_udp
                    && (in_range(frame_in.src_port, rng_start_q[i], rng_end_q[i])
                    || in_range(frame_in.dst_port, rng_start_q[i], rng_end_q[i]));
                AKG_RNG_VID: hits[i] = in_range({4'h0, frame_in.classified_vid},
                    rng_start_q[i], rng_end_q[i]);
                AKG_RNG_DSCP: hits[i] = frame_in.is_ip && in_range({10'h000,
                    frame_in.classified_dscp}, rng_start_q[i], rng_end_q[i]);
                AKG_RNG_FIELD: hits[i] = in_range(sel_field, rng_start_q[i], rng_end_q[i]);
                default: hits[i] = 1'b0;
            endcase
            hits[i] = hits[i] && rng_key;
        end
    end

    // ingress mask selector and bitmap
    logic [1:0] msel;
    logic [AKG_NUM_PORTS-1:0] mbits;
    always_comb begin
        mbits = port_bit(frame_in.port);
        case (frame_in.ifc)
            AKG_IF_FRONT: msel = AKG_SEL0;
            AKG_IF_LOOP: msel = misc_q[AKG_MISC_LOOP_BIT] ? AKG_SEL3 : AKG_SEL1;
            AKG_IF_MASQ: msel = misc_q[AKG_MISC_MASQ_BIT] ? AKG_SEL2 : AKG_SEL0;
            AKG_IF_VD: msel = misc_q[AKG_MISC_VD_BIT] ? AKG_SEL3 : AKG_SEL0;
            AKG_IF_CPU: begin
                msel = misc_q[AKG_MISC_CPU_BIT] ? AKG_SEL3 : AKG_SEL0;
                mbits = '0;
            end
            default: msel = AKG_SEL0;
        endcase
    end

    // registered key fields
    logic route_legs;
    assign route_legs = frame_in.routable_flag && (frame_in.port < AKG_PORT_W'(AKG_NUM_PORTS))
                     && leg_ena_q[frame_in.port];
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            keys_valid_q <= 1'b0;
            keys_q <= '0;
            last_hits_q <= '0;
        end else if (clk_en) begin
            keys_valid_q <= frame_valid;
            if (frame_valid) begin
                keys_q.raw_used <= frame_in.raw_key_enable;
                keys_q.raw_valid <= frame_in.raw_key_enable && raw_pos_ok;
                for (int b = 0; b < AKG_WIDE_BYTES; b++) begin
                    keys_q.wide_key[b*8 +: 8] <= frame_byte(frame_in, raw_start + 8'(b));
                end
                for (int b = 0; b < AKG_NARROW_BYTES; b++) begin
                    keys_q.narrow_key[b*8 +: 8] <= frame_byte(frame_in, raw_start + 8'(b));
                end
                keys_q.range_hit_vector <= hits;
                last_hits_q <= hits;
                keys_q.vid_first <= route_legs ? frame_in.ingress_router_leg
                                              : frame_in.classified_vid;
                keys_q.vid_second <= route_legs ? frame_in.egress_router_leg
                                               : frame_in.classified_vid;
                keys_q.mask_present <= (frame_in.key_type != AKG_KEY_IPV4_VLAN)
                                    && (frame_in.key_type != AKG_KEY_IPV6_VLAN);
                keys_q.ingress_mask_selector <= msel;
                keys_q.ingress_port_bitmap <= mbits;
            end
        end
    end

endmodule

// *** shared/akg_pkg.sv ***
// akg_pkg: constants, types and register map for the acl key field generator.
// assumes a single 125 MHz clock domain and a plain register port.
package akg_pkg;

    localparam int AKG_WIDE_BYTES = 57;
    localparam int AKG_NARROW_BYTES = 24;
    localparam int AKG_FRAME_BYTES = 128;
    localparam int AKG_NUM_RNG = 8;
    localparam int AKG_NUM_PORTS = 53;
    localparam int AKG_PORT_W = 6;
    localparam logic [7:0] AKG_PLUS20 = 8'h14;
    localparam logic [7:0] AKG_PLUS40 = 8'h28;
    localparam int AKG_SEL_FIELD_W = 16;
    localparam int AKG_MAX_VLAN_TAGS = 3;

    // register map (word addresses on the register port)
    localparam logic [7:0] AKG_REG_TYPE_BASE = 8'h00;
    localparam logic [7:0] AKG_REG_BOUNDS_BASE = 8'h08;
    localparam logic [7:0] AKG_REG_OFFSET = 8'h10;
    localparam logic [7:0] AKG_REG_MISC = 8'h11;
    localparam logic [7:0] AKG_REG_LEG_ENA_LO = 8'h12;
    localparam logic [7:0] AKG_REG_LEG_ENA_HI = 8'h13;
    localparam logic [7:0] AKG_REG_HITS = 8'h14;

    localparam logic [31:0] AKG_RST_ZERO = 32'h0000_0000;
    localparam int AKG_MISC_LOOP_BIT = 0;
    localparam int AKG_MISC_MASQ_BIT = 1;
    localparam int AKG_MISC_VD_BIT = 2;
    localparam int AKG_MISC_CPU_BIT = 3;

    localparam logic [1:0] AKG_SEL0 = 2'h0;
    localparam logic [1:0] AKG_SEL1 = 2'h1;
    localparam logic [1:0] AKG_SEL2 = 2'h2;
    localparam logic [1:0] AKG_SEL3 = 2'h3;

    typedef enum logic [2:0] {
        AKG_RNG_DPORT, AKG_RNG_SPORT, AKG_RNG_SDPORT, AKG_RNG_VID, AKG_RNG_DSCP, AKG_RNG_FIELD
    } akg_rng_type_t;

    typedef enum logic [1:0] {
        AKG_POS_LINK, AKG_POS_PAYLOAD, AKG_POS_PLUS20, AKG_POS_PLUS40
    } akg_pos_t;

    typedef enum logic [2:0] {
        AKG_IF_FRONT, AKG_IF_LOOP, AKG_IF_MASQ, AKG_IF_VD, AKG_IF_CPU
    } akg_ifc_t;

    typedef enum logic [2:0] {
        AKG_KEY_IPV4_L4, AKG_KEY_SEVEN_TUPLE, AKG_KEY_IPV4_VLAN, AKG_KEY_IPV6_VLAN, AKG_KEY_OTHER
    } akg_key_t;

    // one frame descriptor from the parser and classification stage
    typedef struct packed {
        logic [AKG_FRAME_BYTES*8-1:0] bytes;
        logic [7:0] payload_pos;
        logic [7:0] typelen_pos;
        logic control_word_frame;
        logic is_tcp_udp;
        logic is_ip;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [11:0] classified_vid;
        logic [5:0] classified_dscp;
        logic raw_key_enable;
        akg_pos_t raw_key_position;
        akg_key_t key_type;
        logic routable_flag;
        logic [11:0] ingress_router_leg;
        logic [11:0] egress_router_leg;
        akg_ifc_t ifc;
        logic [AKG_PORT_W-1:0] port;
    } akg_frame_t;

    typedef struct packed {
        logic raw_used;
        logic raw_valid;
        logic [AKG_WIDE_BYTES*8-1:0] wide_key;
        logic [AKG_NARROW_BYTES*8-1:0] narrow_key;
        logic [AKG_NUM_RNG-1:0] range_hit_vector;
        logic [11:0] vid_first;
        logic [11:0] vid_second;
        logic mask_present;
        logic [1:0] ingress_mask_selector;
        logic [AKG_NUM_PORTS-1:0] ingress_port_bitmap;
    } akg_keys_t;

endpackage

// *** tb/akg_checker.sv ***
// akg_checker: port assertions for akg_key_gen.
// assumes it is bound to every akg_key_gen instance.
`timescale 1ns/1ps
module akg_checker
    import akg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata_q,
    input wire logic frame_valid,
    input wire akg_frame_t frame_in,
    input wire logic keys_valid_q,
    input wire akg_keys_t keys_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [AKG_NUM_PORTS-1:0] one_hot;
    assign one_hot = AKG_NUM_PORTS'(1) << frame_in.port;
    sequence took;
        clk_en && frame_valid;
    endsequence
    sequence masked(akg_ifc_t k);
        took ##0 frame_in.ifc == k && frame_in.port < AKG_NUM_PORTS
            && !(frame_in.key_type inside {AKG_KEY_IPV4_VLAN, AKG_KEY_IPV6_VLAN});
    endsequence
    sequence raw_link;
        took ##0 frame_in.raw_key_enable && frame_in.raw_key_position == AKG_POS_LINK;
    endsequence
    // optional selector leaves the bitmap open
    property mask_p(akg_ifc_t k, logic [1:0] dflt, logic [1:0] opt, logic empty);
        masked(k) |=> keys_q.ingress_mask_selector == opt || (keys_q.ingress_mask_selector
            == dflt && keys_q.ingress_port_bitmap == (empty ? '0 : $past(one_hot)));
    endproperty
    raw_gate_a: assert property (took ##0 !frame_in.raw_key_enable |=>
        !keys_q.raw_used) else $error("raw key used while off");
    link_raw_a: assert property (raw_link ##0 !frame_in.control_word_frame |=>
        keys_q.wide_key == $past(frame_in.bytes[AKG_WIDE_BYTES*8-1:0])
        && keys_q.narrow_key == $past(frame_in.bytes[AKG_NARROW_BYTES*8-1:0]))
        else $error("raw key not from first byte");
    cw_no_link_a: assert property (raw_link ##0 frame_in.control_word_frame |=>
        !keys_q.raw_valid) else $error("link position on control word frame");
    hits_gate_a: assert property (took ##0 !(frame_in.key_type inside
        {AKG_KEY_IPV4_L4, AKG_KEY_SEVEN_TUPLE}) |=> keys_q.range_hit_vector == '0)
        else $error("range hits on other key");
    vid_default_a: assert property (took ##0 !frame_in.routable_flag |=>
        keys_q.vid_first == $past(frame_in.classified_vid)
        && keys_q.vid_second == $past(frame_in.classified_vid)) else $error("vid not classified");
    front_mask_a: assert property (masked(AKG_IF_FRONT) |=>
        keys_q.ingress_mask_selector == AKG_SEL0 && keys_q.ingress_port_bitmap == $past(one_hot))
        else $error("front mask wrong");
    loop_mask_a: assert property (mask_p(AKG_IF_LOOP, AKG_SEL1, AKG_SEL3, 1'b0))
        else $error("loopback mask wrong");
    masq_mask_a: assert property (mask_p(AKG_IF_MASQ, AKG_SEL0, AKG_SEL2, 1'b0))
        else $error("masquerade mask wrong");
    vd_mask_a: assert property (mask_p(AKG_IF_VD, AKG_SEL0, AKG_SEL3, 1'b0))
        else $error("virtual device mask wrong");
    cpu_mask_a: assert property (mask_p(AKG_IF_CPU, AKG_SEL0, AKG_SEL3, 1'b1))
        else $error("cpu mask wrong");
    mask_field_a: assert property (took |=> keys_q.mask_present ==
        !($past(frame_in.key_type) inside {AKG_KEY_IPV4_VLAN, AKG_KEY_IPV6_VLAN}))
        else $error("mask field presence wrong");
endmodule

bind akg_key_gen akg_checker i_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .frame_valid(frame_valid), .frame_in(frame_in),
    .keys_valid_q(keys_valid_q), .keys_q(keys_q));

// *** tb/akg_frame_src.sv ***
// akg_frame_src: parser and classification model handing over frame descriptors.
// assumes the bench calls send once reset is released.
`timescale 1ns/1ps
module akg_frame_src
    import akg_pkg::*;
(
    input wire logic clk,
    output logic frame_valid,
    output akg_frame_t frame_in
);
    initial begin
        frame_valid = 1'b0;
        frame_in = '0;
    end
    task automatic send(input akg_frame_t f, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_in <= f;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_in <= ~f; // stale descriptor never repeats
    endtask
endmodule

// *** tb/akg_key_gen_tb.sv ***
// akg_key_gen_tb: directed bench for akg_key_gen.
// assumes one 125 MHz clock; clk_en held high except during the final ignored-frame check.
`timescale 1ns/1ps
module akg_key_gen_tb
    import akg_pkg::*;
();
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata_q;
    logic frame_valid;
    logic keys_valid_q;
    akg_frame_t frame_in;
    akg_frame_t f;
    akg_keys_t keys_q;
    logic [AKG_WIDE_BYTES*8-1:0] w;
    int st;
    int bad_count = 0;
    int tests_run = 0;
    logic [23:0] typ = 24'h2A_C688;
    logic [9:0] sel_def = 10'h004;
    logic [9:0] sel_opt = 10'h3EC;
    logic [31:0] bnd [8] = '{32'h00C8_0064, 32'h0032_0032, 32'h003C_0028, 32'h0014_000A,
        32'h0008_0008, 32'h0E0F_0E0F, 32'h00C8_00C8, 32'h0031_0000};

    always #4 clk = ~clk;

    akg_key_gen i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_q(reg_rdata_q), .frame_valid(frame_valid), .frame_in(frame_in),
        .keys_valid_q(keys_valid_q), .keys_q(keys_q));
    akg_frame_src i_src (.clk(clk), .frame_valid(frame_valid), .frame_in(frame_in));

    task automatic chk(input string name, input logic [511:0] exp, input logic [511:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata_q", e, reg_rdata_q);
    endtask
    task automatic frame(input akg_frame_t x, input int gap);
        i_src.send(x, gap);
        #1;
        chk("keys_valid_q", 1'b1, keys_valid_q);
    endtask
    // frame byte n holds n; type/len at 12, payload at 14
    function automatic akg_frame_t base();
        akg_frame_t r;
        r = '0;
        for (int n = 0; n < AKG_FRAME_BYTES; n++) r.bytes[8*n +: 8] = 8'(n);
        r.payload_pos = 8'h0E;
        r.typelen_pos = 8'h0C;
        r.classified_vid = 12'h014;
        r.ingress_router_leg = 12'h111;
        r.egress_router_leg = 12'h222;
        r.port = 6'h07;
        return r;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 22; a++) rd(8'(a), 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wr(AKG_REG_TYPE_BASE + 8'(i), {29'h0, typ[3*i +: 3]});
            wr(AKG_REG_BOUNDS_BASE + 8'(i), bnd[i]);
        end
        wr(AKG_REG_OFFSET, 32'h0000_0002);
        rd(AKG_REG_BOUNDS_BASE + 8'h05, bnd[5]);
        f = base();
        f.is_tcp_udp = 1'b1;
        f.is_ip = 1'b1;
        f.dst_port = 16'h00C8;
        f.src_port = 16'h0032;
        f.classified_dscp = 6'h08;
        frame(f, 0);
        chk("hits", 8'h7F, keys_q.range_hit_vector);
        rd(AKG_REG_HITS, 32'h0000_007F);
        f.is_tcp_udp = 1'b0;
        f.is_ip = 1'b0;
        f.key_type = AKG_KEY_SEVEN_TUPLE;
        frame(f, 1);
        chk("hits", 8'h28, keys_q.range_hit_vector);
        f.key_type = AKG_KEY_OTHER;
        frame(f, 0);
        chk("hits", 8'h00, keys_q.range_hit_vector);
        wr(AKG_REG_LEG_ENA_LO, 32'h0000_0020);
        for (int k = 0; k < 4; k++) begin
            f = base();
            f.port = 6'(5 + k % 2);
            f.routable_flag = k / 2;
            frame(f, k);
            chk("vid_first", k == 2 ? 12'h111 : 12'h014, keys_q.vid_first);
            chk("vid_second", k == 2 ? 12'h222 : 12'h014, keys_q.vid_second);
        end
        for (int m = 0; m < 2; m++) begin
            wr(AKG_REG_MISC, m ? 32'h0000_000F : 32'h0000_0000);
            for (int i = 0; i < 5; i++) begin
                f = base();
                f.ifc = akg_ifc_t'(i);
                frame(f, 0);
                chk("sel", m ? sel_opt[2*i +: 2] : sel_def[2*i +: 2],
                    keys_q.ingress_mask_selector);
                if (m == 0) begin
                    chk("bitmap", i == 4 ? 8'h00 : 8'h80,
                        keys_q.ingress_port_bitmap);
                    chk("mask_present", 1'b1, keys_q.mask_present);
                end
            end
        end
        f = base();
        f.key_type = AKG_KEY_IPV6_VLAN;
        frame(f, 0);
        chk("mask_present", 1'b0, keys_q.mask_present);
        for (int p = 0; p < 8; p++) begin
            f = base();
            f.raw_key_enable = 1'b1;
            f.raw_key_position = akg_pos_t'(p % 4);
            f.control_word_frame = p / 4;
            frame(f, 0);
            st = (p % 4 == 0) ? 0 : 20 * (p % 4) - 6;
            for (int b = 0; b < AKG_WIDE_BYTES; b++) w[8*b +: 8] = 8'(st + b);
            chk("raw_valid", p != 4, keys_q.raw_valid);
            if (p != 4) begin
                chk("wide_key", w, keys_q.wide_key);
                chk("narrow_key", w[AKG_NARROW_BYTES*8-1:0], keys_q.narrow_key);
            end
        end
        f.raw_key_enable = 1'b0;
        frame(f, 0);
        chk("raw_used", 1'b0, keys_q.raw_used);
        // frame offered while the clock enable is low must be ignored
        @(posedge clk);
        clk_en <= 1'b0;
        i_src.send(base(), 0);
        #1;
        chk("keys_valid_q", 1'b0, keys_valid_q);
        @(posedge clk);
        clk_en <= 1'b1;
        tally_and_finish();
    end
endmodule
